/* design/cbr_pkg.sv */
// Constants and carrier types shared by the banked register file.
// Function
// - Thirteen registers, seven kept in two banks.
// - Flag bit four picks bank zero or one.
// - Four sixteen-bit data words, read and written.
// - Data words zero, one split into bytes.
// - Words two:zero and three:one form 32-bit pairs.
// - Two sixteen-bit address words, usable as data.
// - Address words one:zero form a 32-bit pair.
// - Sixteen-bit frame base for relative addressing.
// - Twenty-bit instruction pointer holds next address.
// - Twenty-bit vector table base register.
// - Separate user and interrupt stack pointers.
// - Flag bit seven selects active stack pointer.
// - Clear selects interrupt, set selects user pointer.
// - Interrupt or low software interrupt clears stack select.
// - Sixteen-bit static base for relative addressing.
// - Decoder spans one megabyte, ROM at top.
// - Peripheral control area from zero to 003FF.
// - RAM starts at 00400 and grows upward.
// - Fixed vector table from FFFDC to top.
// - Special page vectors from FFE00 to FFFDB.
package cbr_pkg;

  // ****************************************************************
  // Register bus map, one aligned word per register.
  // ****************************************************************
  localparam logic [7:0] OFS_DATA0   = 8'h00;
  localparam logic [7:0] OFS_DATA1   = 8'h04;
  localparam logic [7:0] OFS_DATA2   = 8'h08;
  localparam logic [7:0] OFS_DATA3   = 8'h0C;
  localparam logic [7:0] OFS_ADDR0   = 8'h10;
  localparam logic [7:0] OFS_ADDR1   = 8'h14;
  localparam logic [7:0] OFS_FRAME   = 8'h18;
  localparam logic [7:0] OFS_IPTR    = 8'h1C;
  localparam logic [7:0] OFS_VTAB    = 8'h20;
  localparam logic [7:0] OFS_USTK    = 8'h24;
  localparam logic [7:0] OFS_ISTK    = 8'h28;
  localparam logic [7:0] OFS_SBASE   = 8'h2C;
  localparam logic [7:0] OFS_FLAG    = 8'h30;
  localparam logic [7:0] OFS_ACTSTK  = 8'h34;
  localparam logic [7:0] OFS_PAIRLO  = 8'h38;
  localparam logic [7:0] OFS_PAIRHI  = 8'h3C;
  localparam logic [7:0] OFS_APAIR   = 8'h40;
  localparam logic [7:0] OFS_DECODE  = 8'h44;

  // ****************************************************************
  // Field positions, widths and reset values.
  // ****************************************************************
  localparam int          BANK_BIT   = 4;
  localparam int          STACK_BIT  = 7;
  localparam int          WORD_W     = 16;
  localparam int          ADDR_W     = 20;
  localparam int          NUM_BANKED = 7;
  localparam int          BANK_IDX_W = 3;
  localparam logic [15:0] FLAG_MASK  = 16'h70FF;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [19:0] ADR_RST    = 20'h0_0000;
  localparam logic [5:0]  SWI_LAST   = 6'h1F;
  localparam logic [5:0]  SWI_NUM_W  = 6'h06;

  // Banked register indices inside one bank.
  localparam logic [2:0] IDX_D0 = 3'h0;
  localparam logic [2:0] IDX_D1 = 3'h1;
  localparam logic [2:0] IDX_D2 = 3'h2;
  localparam logic [2:0] IDX_D3 = 3'h3;
  localparam logic [2:0] IDX_A0 = 3'h4;
  localparam logic [2:0] IDX_A1 = 3'h5;
  localparam logic [2:0] IDX_FB = 3'h6;

  // ****************************************************************
  // Address map boundaries.
  // ****************************************************************
  localparam logic [19:0] PERIPH_LAST = 20'h0_03FF;
  localparam logic [19:0] RAM_FIRST   = 20'h0_0400;
  localparam logic [19:0] SPAGE_FIRST = 20'hF_FE00;
  localparam logic [19:0] SPAGE_LAST  = 20'hF_FFDB;
  localparam logic [19:0] FIXV_FIRST  = 20'hF_FFDC;

  // Region codes reported by the decoder.
  typedef enum logic [2:0] {
    CBR_REG_PERIPH,
    CBR_REG_RAM,
    CBR_REG_ROM,
    CBR_REG_SPAGE,
    CBR_REG_FIXVEC
  } cbr_region_e;

  // Result of one address classification.
  typedef struct packed {
    cbr_region_e region;
    logic        periph;
    logic        ram;
    logic        rom;
    logic        spage;
    logic        fixvec;
  } cbr_decode_s;

  // Write port of the banked store.
  typedef struct packed {
    logic        we;
    logic        bank;
    logic [2:0]  idx;
    logic [1:0]  lanes;
    logic [15:0] data;
  } cbr_bwrite_s;

endpackage : cbr_pkg

/* design/cbr_bank_store.sv */
// Two-bank store of the seven banked core registers.
`timescale 1ns/1ps
`default_nettype none
module cbr_bank_store #(
  parameter int NREG = cbr_pkg::NUM_BANKED
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire cbr_pkg::cbr_bwrite_s wr,
  input  wire logic                rd_bank,
  output var  logic [NREG*16-1:0]  rd_all
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  typedef struct packed {
    logic [1:0][NREG-1:0][15:0] mem;
  } cbr_store_s;

  cbr_store_s st_reg;
  cbr_store_s st_next;

  // Refuse a store size that the fixed slot map cannot address.
  if (NREG != cbr_pkg::NUM_BANKED) begin : g_bad_nreg
    $error("Bank store needs seven registers.");
  end

  // Byte-lane write into the addressed bank and slot.
  always_comb begin
    st_next = st_reg;
    if (wr.we) begin
      if (wr.lanes[0]) st_next.mem[wr.bank][wr.idx][7:0]  = wr.data[7:0];
      if (wr.lanes[1]) st_next.mem[wr.bank][wr.idx][15:8] = wr.data[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Reads come straight from the selected bank, so a bank flip shows at once.
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_rd
      assign rd_all[g*16 +: 16] = st_reg.mem[rd_bank][g];
    end
  endgenerate

endmodule : cbr_bank_store
`default_nettype wire

/* design/cbr_addr_decode.sv */
// Address classifier for the one-megabyte map.
`timescale 1ns/1ps
`default_nettype none
module cbr_addr_decode #(
  parameter logic [19:0] ROM_FIRST = 20'hE_0000
) (
  input  wire logic [19:0]          addr,
  output var  cbr_pkg::cbr_decode_s dec
);

  // ROM must sit between RAM start and the special page, or regions would overlap.
  if (ROM_FIRST <= cbr_pkg::RAM_FIRST || ROM_FIRST > cbr_pkg::SPAGE_FIRST) begin : g_bad_rom
    $error("ROM must lie above RAM start and below the special page.");
  end

  // Fixed vectors win over special page, which wins over plain ROM.
  always_comb begin
    dec = '0;
    if (addr >= cbr_pkg::FIXV_FIRST) begin
      dec.region = cbr_pkg::CBR_REG_FIXVEC;
      dec.fixvec = 1'b1;
    end else if (addr >= cbr_pkg::SPAGE_FIRST) begin
      dec.region = cbr_pkg::CBR_REG_SPAGE;
      dec.spage  = 1'b1;
    end else if (addr >= ROM_FIRST) begin
      dec.region = cbr_pkg::CBR_REG_ROM;
      dec.rom    = 1'b1;
    end else if (addr >= cbr_pkg::RAM_FIRST) begin
      dec.region = cbr_pkg::CBR_REG_RAM;
      dec.ram    = 1'b1;
    end else begin
      dec.region = cbr_pkg::CBR_REG_PERIPH;
      dec.periph = 1'b1;
    end
  end

endmodule : cbr_addr_decode
`default_nettype wire

/* design/cbr_register_file.sv */
// Top of the banked core register file with a classic Wishbone slave.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cbr_register_file #(
  parameter logic [19:0] ROM_FIRST = 20'hE_0000
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  output var  logic        WB_ERR_O,
  input  wire logic        HW_INT_ACK,
  input  wire logic        SW_INT_EXEC,
  input  wire logic [5:0]  SW_INT_NUM,
  output var  logic [15:0] ACTIVE_STACK,
  output var  logic        BANK_SEL,
  output var  logic        STACK_SEL,
  output var  logic [19:0] INSTR_PTR
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [15:0] flag;
    logic [19:0] iptr;
    logic [19:0] vtab;
    logic [15:0] ustk;
    logic [15:0] istk;
    logic [15:0] sbase;
    logic [19:0] probe;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } cbr_state_s;

  cbr_state_s s_reg;
  cbr_state_s s_next;

  cbr_pkg::cbr_bwrite_s bw;
  cbr_pkg::cbr_decode_s dec;
  logic [cbr_pkg::NUM_BANKED*16-1:0] banked;
  logic [15:0] d0;
  logic [15:0] d1;
  logic [15:0] d2;
  logic [15:0] d3;
  logic [15:0] a0;
  logic [15:0] a1;
  logic [15:0] fb;
  logic        req;
  logic        wr;
  logic        bank_now;
  logic        hit;
  logic [31:0] rd_mux;
  logic [15:0] wlo;
  logic [1:0]  lanes;
  logic [2:0]  widx;
  logic        bwe;
  logic [15:0] flag_w;

  // A new request is one that has not been answered yet.
  assign req = WB_CYC_I && WB_STB_I && !s_reg.ack && !s_reg.err;
  assign wr  = req && WB_WE_I;
  assign wlo = WB_DAT_I[15:0];
  assign lanes = WB_SEL_I[1:0];

  // Bank follows the live flag bit, so reads never lag a bank switch.
  assign bank_now = s_reg.flag[cbr_pkg::BANK_BIT];

  // ****************************************************************
  // Banked store and decoder.
  // ****************************************************************
  cbr_bank_store #(
    .NREG (cbr_pkg::NUM_BANKED)
  ) u_bank (
    .clk     (CLK),
    .rst_b   (RST_B),
    .wr      (bw),
    .rd_bank (bank_now),
    .rd_all  (banked)
  );

  cbr_addr_decode #(
    .ROM_FIRST (ROM_FIRST)
  ) u_dec (
    .addr (s_reg.probe),
    .dec  (dec)
  );

  // Unpack the current bank's seven words.
  assign d0 = banked[cbr_pkg::IDX_D0*16 +: 16];
  assign d1 = banked[cbr_pkg::IDX_D1*16 +: 16];
  assign d2 = banked[cbr_pkg::IDX_D2*16 +: 16];
  assign d3 = banked[cbr_pkg::IDX_D3*16 +: 16];
  assign a0 = banked[cbr_pkg::IDX_A0*16 +: 16];
  assign a1 = banked[cbr_pkg::IDX_A1*16 +: 16];
  assign fb = banked[cbr_pkg::IDX_FB*16 +: 16];

  // Map a bus offset onto a banked slot; byte lanes give the byte halves.
  always_comb begin
    widx = cbr_pkg::IDX_D0;
    bwe  = 1'b0;
    case (WB_ADR_I)
      cbr_pkg::OFS_DATA0: begin widx = cbr_pkg::IDX_D0; bwe = wr; end
      cbr_pkg::OFS_DATA1: begin widx = cbr_pkg::IDX_D1; bwe = wr; end
      cbr_pkg::OFS_DATA2: begin widx = cbr_pkg::IDX_D2; bwe = wr; end
      cbr_pkg::OFS_DATA3: begin widx = cbr_pkg::IDX_D3; bwe = wr; end
      cbr_pkg::OFS_ADDR0: begin widx = cbr_pkg::IDX_A0; bwe = wr; end
      cbr_pkg::OFS_ADDR1: begin widx = cbr_pkg::IDX_A1; bwe = wr; end
      cbr_pkg::OFS_FRAME: begin widx = cbr_pkg::IDX_FB; bwe = wr; end
      default:            begin widx = cbr_pkg::IDX_D0; bwe = 1'b0; end
    endcase
  end

  // Writes always land in the bank selected at the moment of the write.
  always_comb begin
    bw       = '0;
    bw.we    = bwe;
    bw.bank  = bank_now;
    bw.idx   = widx;
    bw.lanes = lanes;
    bw.data  = wlo;
  end

  // Read multiplexer, including the 32-bit pair views and decoder result.
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (WB_ADR_I)
      cbr_pkg::OFS_DATA0:  rd_mux = {16'h0000, d0};
      cbr_pkg::OFS_DATA1:  rd_mux = {16'h0000, d1};
      cbr_pkg::OFS_DATA2:  rd_mux = {16'h0000, d2};
      cbr_pkg::OFS_DATA3:  rd_mux = {16'h0000, d3};
      cbr_pkg::OFS_ADDR0:  rd_mux = {16'h0000, a0};
      cbr_pkg::OFS_ADDR1:  rd_mux = {16'h0000, a1};
      cbr_pkg::OFS_FRAME:  rd_mux = {16'h0000, fb};
      cbr_pkg::OFS_IPTR:   rd_mux = {12'h000, s_reg.iptr};
      cbr_pkg::OFS_VTAB:   rd_mux = {12'h000, s_reg.vtab};
      cbr_pkg::OFS_USTK:   rd_mux = {16'h0000, s_reg.ustk};
      cbr_pkg::OFS_ISTK:   rd_mux = {16'h0000, s_reg.istk};
      cbr_pkg::OFS_SBASE:  rd_mux = {16'h0000, s_reg.sbase};
      cbr_pkg::OFS_FLAG:   rd_mux = {16'h0000, s_reg.flag};
      cbr_pkg::OFS_ACTSTK: rd_mux = {16'h0000, ACTIVE_STACK};
      cbr_pkg::OFS_PAIRLO: rd_mux = {d2, d0};
      cbr_pkg::OFS_PAIRHI: rd_mux = {d3, d1};
      cbr_pkg::OFS_APAIR:  rd_mux = {a1, a0};
      cbr_pkg::OFS_DECODE: rd_mux = {4'h0, dec, s_reg.probe};
      default: begin
        hit    = 1'b0;
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Byte-lane merge for the flag word; reserved bits stay zero.
  always_comb begin
    flag_w = s_reg.flag;
    if (lanes[0]) flag_w[7:0]  = wlo[7:0];
    if (lanes[1]) flag_w[15:8] = wlo[15:8];
    flag_w = flag_w & cbr_pkg::FLAG_MASK;
  end

  // ****************************************************************
  // Next-state logic for the unbanked registers and bus answer.
  // ****************************************************************
  always_comb begin
    s_next       = s_reg;
    s_next.ack   = 1'b0;
    s_next.err   = 1'b0;
    if (req) begin
      s_next.ack   = hit;
      s_next.err   = !hit;
      s_next.rdata = hit ? rd_mux : 32'h0000_0000;
    end
    if (wr) begin
      case (WB_ADR_I)
        cbr_pkg::OFS_IPTR: begin
          if (WB_SEL_I[0]) s_next.iptr[7:0]   = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_next.iptr[15:8]  = WB_DAT_I[15:8];
          if (WB_SEL_I[2]) s_next.iptr[19:16] = WB_DAT_I[19:16];
        end
        cbr_pkg::OFS_VTAB: begin
          if (WB_SEL_I[0]) s_next.vtab[7:0]   = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_next.vtab[15:8]  = WB_DAT_I[15:8];
          if (WB_SEL_I[2]) s_next.vtab[19:16] = WB_DAT_I[19:16];
        end
        cbr_pkg::OFS_DECODE: begin
          if (WB_SEL_I[0]) s_next.probe[7:0]   = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_next.probe[15:8]  = WB_DAT_I[15:8];
          if (WB_SEL_I[2]) s_next.probe[19:16] = WB_DAT_I[19:16];
        end
        cbr_pkg::OFS_USTK: begin
          if (lanes[0]) s_next.ustk[7:0]  = wlo[7:0];
          if (lanes[1]) s_next.ustk[15:8] = wlo[15:8];
        end
        cbr_pkg::OFS_ISTK: begin
          if (lanes[0]) s_next.istk[7:0]  = wlo[7:0];
          if (lanes[1]) s_next.istk[15:8] = wlo[15:8];
        end
        cbr_pkg::OFS_SBASE: begin
          if (lanes[0]) s_next.sbase[7:0]  = wlo[7:0];
          if (lanes[1]) s_next.sbase[15:8] = wlo[15:8];
        end
        cbr_pkg::OFS_ACTSTK: begin
          if (s_reg.flag[cbr_pkg::STACK_BIT]) begin
            if (lanes[0]) s_next.ustk[7:0]  = wlo[7:0];
            if (lanes[1]) s_next.ustk[15:8] = wlo[15:8];
          end else begin
            if (lanes[0]) s_next.istk[7:0]  = wlo[7:0];
            if (lanes[1]) s_next.istk[15:8] = wlo[15:8];
          end
        end
        cbr_pkg::OFS_FLAG: s_next.flag = flag_w;
        default: s_next.flag = s_reg.flag;
      endcase
    end
    // An interrupt entry beats a same-cycle software write of the flag.
    if (HW_INT_ACK || (SW_INT_EXEC && (SW_INT_NUM <= cbr_pkg::SWI_LAST))) begin
      s_next.flag[cbr_pkg::STACK_BIT] = 1'b0;
    end
  end

  // Single register stage for all unbanked state.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign WB_ACK_O  = s_reg.ack;
  assign WB_ERR_O  = s_reg.err;
  assign WB_DAT_O  = s_reg.rdata;
  assign BANK_SEL  = s_reg.flag[cbr_pkg::BANK_BIT];
  assign STACK_SEL = s_reg.flag[cbr_pkg::STACK_BIT];
  assign INSTR_PTR = s_reg.iptr;

  // Clear picks the interrupt stack, set picks the user stack.
  assign ACTIVE_STACK = s_reg.flag[cbr_pkg::STACK_BIT] ? s_reg.ustk : s_reg.istk;

endmodule : cbr_register_file
`default_nettype wire

/* bench/cbr_register_file_chk.sv */
// Port-level assertions for the banked register file, bound to its top.
`timescale 1ns/1ps
`default_nettype none
module cbr_register_file_chk (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic        HW_INT_ACK,
  input wire logic        SW_INT_EXEC,
  input wire logic [5:0]  SW_INT_NUM,
  input wire logic [15:0] ACTIVE_STACK,
  input wire logic        BANK_SEL,
  input wire logic        STACK_SEL,
  input wire logic [19:0] INSTR_PTR
);
  logic take;
  logic int_clr;
  logic wr_flag;

  // A request counts only once; the held cycle that shows the answer is not a new one.
  assign take    = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign int_clr = HW_INT_ACK || (SW_INT_EXEC && SW_INT_NUM <= 6'h1F);
  assign wr_flag = take && WB_WE_I && WB_ADR_I == 8'h30 && WB_SEL_I[0];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_take_answer: assert property (take |=> WB_ACK_O != WB_ERR_O)
    else $error("request not answered by exactly one of ack and err");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood longer than one cycle");
  a_unmapped_err: assert property (take && WB_ADR_I >= 8'h48 |=> WB_ERR_O)
    else $error("unmapped offset not refused");
  a_bank_write: assert property (wr_flag |=> BANK_SEL == $past(WB_DAT_I[4]))
    else $error("bank select does not follow flag write");
  a_bank_hold: assert property (!take |=> $stable(BANK_SEL))
    else $error("bank select moved without a write");
  a_stack_write: assert property (wr_flag && !int_clr |=> STACK_SEL == $past(WB_DAT_I[7]))
    else $error("stack select does not follow flag write");
  a_stack_clear: assert property (int_clr |=> !STACK_SEL)
    else $error("interrupt did not clear stack select");
  a_stack_keep: assert property (SW_INT_EXEC && !int_clr && !take |=> $stable(STACK_SEL))
    else $error("high software interrupt changed stack select");
  a_active_write: assert property (take && WB_WE_I && WB_ADR_I == 8'h34 && WB_SEL_I[1:0] == 2'b11
    && !int_clr |=> ACTIVE_STACK == $past(WB_DAT_I[15:0]))
    else $error("active stack write lost");
  a_ip_write: assert property (take && WB_WE_I && WB_ADR_I == 8'h1C && WB_SEL_I[2:0] == 3'b111
    |=> INSTR_PTR == $past(WB_DAT_I[19:0]))
    else $error("instruction pointer write lost");
  a_ip_hold: assert property (!take |=> $stable(INSTR_PTR))
    else $error("instruction pointer moved without a write");

  // Main scenarios seen at least once.
  cover property (wr_flag);
  cover property (HW_INT_ACK);
  cover property (take && WB_ADR_I >= 8'h48);
endmodule : cbr_register_file_chk

bind cbr_register_file cbr_register_file_chk u_chk (.CLK(CLK), .RST_B(RST_B),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .HW_INT_ACK(HW_INT_ACK), .SW_INT_EXEC(SW_INT_EXEC), .SW_INT_NUM(SW_INT_NUM),
  .ACTIVE_STACK(ACTIVE_STACK), .BANK_SEL(BANK_SEL), .STACK_SEL(STACK_SEL),
  .INSTR_PTR(INSTR_PTR));
`default_nettype wire

/* bench/cbr_register_file_tb.sv */
// Self-checking bench for the banked register file.
`timescale 1ns/1ps
`default_nettype none
module cbr_register_file_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, hw_ack = 1'b0, sw_exec = 1'b0;
  logic [5:0]  sw_num = 6'h00;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, rd;
  logic        ack, err, bank_sel, stack_sel, got_err;
  logic [15:0] act_stk;
  logic [19:0] iptr;
  int          fails = 0, checked = 0;
  logic [7:0]  ofs [9] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  logic [7:0]  kind [5] = '{8'h80, 8'h1F, 8'h60, 8'h00, 8'h7F};
  logic [22:0] dec [10] = '{{3'd0, 20'h0_0000}, {3'd0, 20'h0_03FF}, {3'd1, 20'h0_0400},
    {3'd1, 20'hD_FFFF}, {3'd2, 20'hE_0000}, {3'd2, 20'hF_FDFF}, {3'd3, 20'hF_FE00},
    {3'd3, 20'hF_FFDB}, {3'd4, 20'hF_FFDC}, {3'd4, 20'hF_FFFF}};

  // Free-running core clock.
  always #5 clk = ~clk;

  cbr_register_file u_cbr_register_file (
    .CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .WB_ERR_O(err), .HW_INT_ACK(hw_ack), .SW_INT_EXEC(sw_exec), .SW_INT_NUM(sw_num),
    .ACTIVE_STACK(act_stk), .BANK_SEL(bank_sel), .STACK_SEL(stack_sel), .INSTR_PTR(iptr));

  task automatic complete_run();
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle. The idle edge first keeps cyc low between cycles.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    rd = dat_o;
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fails++;
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'hF, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  // Bit 7 picks a hardware acknowledge, else a software interrupt of number k[5:0].
  task automatic pulse(input logic [7:0] k);
    @(posedge clk);
    hw_ack <= k[7];
    sw_exec <= !k[7];
    sw_num <= k[5:0];
    @(posedge clk);
    hw_ack <= 1'b0;
    sw_exec <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // Main sequence: reset, widths, banks, views, stacks, decoder, refusals.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) rdchk(8'(4 * i), 32'h0000_0000);
    foreach (ofs[i]) begin
      wr(ofs[i], 32'hFFFF_FFFF);
      rdchk(ofs[i], (ofs[i] == 8'h1C || ofs[i] == 8'h20) ? 32'h000F_FFFF : 32'h0000_FFFF);
    end
    check(32'(iptr), 32'h000F_FFFF);
    // Bank one must start clear and bank zero must survive the round trip.
    for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'(16'h1000 + i));
    wr(8'h30, 32'h0000_0010);
    check(32'(bank_sel), 32'h0000_0001);
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'(16'h2000 + i));
    wr(8'h30, 32'h0000_0000);
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), 32'(16'h1000 + i));
    rdchk(8'h24, 32'h0000_FFFF);
    rdchk(8'h38, 32'h1002_1000);
    rdchk(8'h3C, 32'h1003_1001);
    rdchk(8'h40, 32'h1005_1004);
    wr(8'h38, 32'hDEAD_BEEF);
    rdchk(8'h00, 32'h0000_1000);
    // Single byte lanes leave the other half alone.
    bus(1'b1, 8'h00, 4'b0001, 32'h0000_00AB);
    bus(1'b1, 8'h04, 4'b0010, 32'h0000_CD00);
    rdchk(8'h00, 32'h0000_10AB);
    rdchk(8'h04, 32'h0000_CD01);
    wr(8'h24, 32'h0000_1111);
    wr(8'h28, 32'h0000_2222);
    check({15'h0000, stack_sel, act_stk}, 32'h0000_2222);
    wr(8'h30, 32'h0000_0080);
    check({15'h0000, stack_sel, act_stk}, 32'h0001_1111);
    wr(8'h34, 32'h0000_3333);
    rdchk(8'h24, 32'h0000_3333);
    rdchk(8'h28, 32'h0000_2222);
    // Hardware acknowledge and low software numbers clear the select; others keep it.
    foreach (kind[i]) begin
      wr(8'h30, 32'h0000_0080);
      pulse(kind[i]);
      check({15'h0000, stack_sel, act_stk}, kind[i][6] ? 32'h0001_3333 : 32'h0000_2222);
    end
    rdchk(8'h30, 32'h0000_0080);
    rdchk(8'h34, 32'h0000_3333);
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0000_70FF);
    rdchk(8'h00, 32'h0000_2000);
    foreach (dec[i]) begin
      wr(8'h44, 32'(dec[i][19:0]));
      bus(1'b0, 8'h44, 4'hF, 32'h0000_0000);
      check(rd, {4'h0, dec[i][22:20], 5'h10 >> dec[i][22:20], dec[i][19:0]});
    end
    bus(1'b0, 8'h48, 4'hF, 32'h0000_0000);
    check({got_err, rd[30:0]}, 32'h8000_0000);
    bus(1'b1, 8'h48, 4'hF, 32'hFFFF_FFFF);
    check(32'(got_err), 32'h0000_0001);
    complete_run();
  end
endmodule : cbr_register_file_tb
`default_nettype wire
